// ==== src/afc_flow_ctrl.sv ====
// Automatic receive flow-control trigger with AHB-Lite register slave
`timescale 1ns/10ps
module afc_flow_ctrl
    import afc_pkg::*;
#(
    parameter int FIFO_BYTES_W = 14
)
(
    input  wire logic                    hclk,
    input  wire logic                    hresetn,
    input  wire logic                    hsel,
    input  wire logic [31:0]             haddr,
    input  wire logic [1:0]              htrans,
    input  wire logic                    hwrite,
    input  wire logic [2:0]              hsize,
    input  wire logic [31:0]             hwdata,
    input  wire logic                    hready,
    output logic                         hreadyout,
    output logic                         hresp,
    output logic [31:0]                  hrdata,
    input  wire logic [FIFO_BYTES_W-1:0] rx_fifo_used_bytes,
    input  wire logic                    full_duplex,
    input  wire logic                    speed_100,
    input  wire logic                    tx_enabled,
    input  wire logic                    rx_frame_start,
    input  wire logic                    rx_multicast,
    input  wire logic                    rx_broadcast,
    input  wire logic                    rx_own_address,
    output logic                         pause_req,
    output logic                         pause_zero,
    input  wire logic                    pause_ack,
    output logic                         jam
);
    // ==========================================================
    // Elaboration checks
    initial
    begin
        if (FIFO_BYTES_W < 7 || FIFO_BYTES_W > 16)
        begin
            $error("FIFO_BYTES_W out of range");
        end
    end

    // ==========================================================
    // State
    typedef struct packed
    {
        logic [23:0]  cfg;
        logic         ph_valid;
        logic         ph_write;
        logic [7:0]   ph_addr;
        logic [31:0]  rdata;
        afc_state_t   mode;
        logic         above_hi;
        logic         pause_req;
        logic         pause_zero;
        logic         sw_pause;
        logic         sw_jam;
        logic [2:0]   tx_en_sync;
        logic         tx_en;
        logic [2:0]   fd_sync;
        logic         fd;
        logic [2:0]   sp_sync;
        logic         sp;
        logic         jam_started;
    } afc_state_s_t;

    afc_state_s_t st;
    afc_state_s_t next_st;
    afc_jam_if    jif ();

    afc_jam_timer u_timer
    (
        .hclk    (hclk),
        .hresetn (hresetn),
        .jam     (jif)
    );

    // ==========================================================
    // Threshold compare
    logic [FIFO_BYTES_W+1:0] hi_bytes;
    logic [FIFO_BYTES_W+1:0] lo_bytes;
    logic [FIFO_BYTES_W+1:0] used;
    logic                    hit_hi;
    logic                    below_lo;
    logic                    frame_match;
    logic                    addr_phase;

    assign hi_bytes = (FIFO_BYTES_W+2)'({st.cfg[HI_LSB +: 8], 6'h00});
    assign lo_bytes = (FIFO_BYTES_W+2)'({st.cfg[LO_LSB +: 8], 6'h00});
    assign used     = (FIFO_BYTES_W+2)'(rx_fifo_used_bytes);
    assign hit_hi   = used >= hi_bytes;
    assign below_lo = used < lo_bytes;
    // Bit 0 overrides the type bits
    assign frame_match = st.cfg[ANY_BIT]
                       | (st.cfg[MULT_BIT] & rx_multicast)
                       | (st.cfg[BRD_BIT] & rx_broadcast)
                       | (st.cfg[ADD_BIT] & rx_own_address);
    assign addr_phase = hsel && hready && htrans[1];

    always_comb
    begin
        next_st = st;
        // Pin-side levels through three stages, change when 2nd and 3rd agree
        next_st.tx_en_sync = {st.tx_en_sync[1:0], tx_enabled};
        if (st.tx_en_sync[1] == st.tx_en_sync[2])
        begin
            next_st.tx_en = st.tx_en_sync[2];
        end
        next_st.fd_sync = {st.fd_sync[1:0], full_duplex};
        if (st.fd_sync[1] == st.fd_sync[2])
        begin
            next_st.fd = st.fd_sync[2];
        end
        next_st.sp_sync = {st.sp_sync[1:0], speed_100};
        if (st.sp_sync[1] == st.sp_sync[2])
        begin
            next_st.sp = st.sp_sync[2];
        end

        // ======================================================
        // Bus slave: zero-wait, write data lands in the data phase
        next_st.ph_valid = addr_phase;
        next_st.ph_write = hwrite;
        next_st.ph_addr  = haddr[7:0];
        next_st.sw_pause = 1'b0;
        next_st.sw_jam   = 1'b0;
        if (st.ph_valid && st.ph_write)
        begin
            case (st.ph_addr)
                CONFIG_OFFSET:
                begin
                    next_st.cfg = hwdata[23:0] & CFG_MASK;
                end
                AFC_SW_OFFSET:
                begin
                    next_st.sw_pause = hwdata[0];
                    next_st.sw_jam   = hwdata[1];
                end
                default:
                begin
                    next_st.cfg = st.cfg;
                end
            endcase
        end
        if (addr_phase && !hwrite)
        begin
            case (haddr[7:0])
                CONFIG_OFFSET:   next_st.rdata = {8'h00, st.cfg};
                AFC_STAT_OFFSET: next_st.rdata = {25'h0000000, st.fd, st.sp, st.tx_en, jif.busy,
                                                  st.above_hi, st.mode};
                default:         next_st.rdata = 32'h00000000;
            endcase
        end

        // ======================================================
        // Flow control
        if (pause_ack && st.pause_req)
        begin
            next_st.pause_req   = 1'b0;
        end
        // Remembers that this jam state has launched the timer
        next_st.jam_started = (st.mode == AFC_JAM) && jif.busy;
        if (!st.tx_en)
        begin
            // Request, high flag and state dropped; pause_zero keeps its value
            next_st.pause_req = 1'b0;
            next_st.mode      = AFC_IDLE;
            next_st.above_hi  = 1'b0;
        end
        else
        begin
            case (st.mode)
                AFC_IDLE:
                begin
                    // A pending zero pause is taken before a new pause
                    if (st.fd && st.cfg[ANY_BIT] && hit_hi && !st.above_hi && !st.pause_req)
                    begin
                        next_st.pause_req  = 1'b1;
                        next_st.pause_zero = 1'b0;
                        next_st.above_hi   = 1'b1;
                        next_st.mode       = AFC_PAUSED;
                    end
                    else if (!st.fd && hit_hi && rx_frame_start && frame_match)
                    begin
                        next_st.mode = AFC_JAM;
                    end
                    else if (st.sw_pause && !st.pause_req)
                    begin
                        next_st.pause_req  = 1'b1;
                        next_st.pause_zero = 1'b0;
                    end
                    else if (st.sw_jam && !st.fd)
                    begin
                        next_st.mode = AFC_JAM;
                    end
                end
                AFC_PAUSED:
                begin
                    // Zero pause only once the earlier pause went out
                    if (below_lo && !st.pause_req && st.cfg[ANY_BIT])
                    begin
                        next_st.pause_req  = 1'b1;
                        next_st.pause_zero = 1'b1;
                        next_st.above_hi   = 1'b0;
                        next_st.mode       = AFC_IDLE;
                    end
                    else if (!st.fd || !st.cfg[ANY_BIT])
                    begin
                        next_st.above_hi = 1'b0;
                        next_st.mode     = AFC_IDLE;
                    end
                end
                AFC_JAM:
                begin
                    if (st.fd)
                    begin
                        next_st.mode = AFC_IDLE;
                    end
                    else if (st.jam_started && !jif.busy)
                    begin
                        next_st.mode = AFC_IDLE;
                    end
                end
                default:
                begin
                    next_st.mode = AFC_IDLE;
                end
            endcase
        end
    end

    // ==========================================================
    // Jam timer hookup
    // One start per jam state, else the timer relaunches as it ends
    assign jif.start     = (st.mode == AFC_JAM) && !st.jam_started && st.tx_en && !st.fd;
    assign jif.code      = st.cfg[DUR_LSB +: 4];
    assign jif.speed_100 = st.sp;

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st      <= '0;
            st.cfg  <= CFG_RESET;
            st.mode <= AFC_IDLE;
        end
        else
        begin
            st <= next_st;
        end
    end

    // ==========================================================
    // Outputs
    assign hreadyout  = 1'b1;
    assign hresp      = 1'b0;
    assign hrdata     = st.rdata;
    assign pause_req  = st.pause_req;
    assign pause_zero = st.pause_zero;
    assign jam        = jif.busy && st.tx_en && !st.fd;

    // ==========================================================
    // Assertions
    a_no_pause_txoff: assert property (@(posedge hclk) disable iff (!hresetn)
        !st.tx_en |=> !pause_req)
        else $error("Pause request while transmitter off");
    a_no_jam_txoff: assert property (@(posedge hclk) disable iff (!hresetn)
        !st.tx_en |-> !jam)
        else $error("Jam while transmitter off");
    a_pause_on_high: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.tx_en && st.fd && st.cfg[ANY_BIT] && st.mode == AFC_IDLE && hit_hi && !st.above_hi && !pause_req)
        |=> (pause_req && !pause_zero))
        else $error("No pause on high crossing");
    a_single_pause: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.mode == AFC_PAUSED) |=> !(pause_req && !pause_zero && !$past(pause_req)))
        else $error("Second pause while above high");
    a_zero_after_hi: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(pause_zero) |-> $past(st.mode) == AFC_PAUSED)
        else $error("Zero pause without prior pause");
    a_zero_below_lo: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.tx_en && st.mode == AFC_PAUSED && below_lo && !pause_req && st.cfg[ANY_BIT])
        |=> (pause_req && pause_zero))
        else $error("No zero pause below low");
    a_req_held: assert property (@(posedge hclk) disable iff (!hresetn)
        (pause_req && !pause_ack && st.tx_en) |=> pause_req)
        else $error("Pause request dropped before taken");
    a_no_jam_fd: assert property (@(posedge hclk) disable iff (!hresetn)
        st.fd |-> !jam)
        else $error("Jam in full duplex");
    a_jam_on_match: assert property (@(posedge hclk) disable iff (!hresetn)
        (st.tx_en && !st.fd && st.mode == AFC_IDLE && hit_hi && rx_frame_start && frame_match)
        |=> st.mode == AFC_JAM)
        else $error("Matching frame not jammed");
    a_any_override: assert property (@(posedge hclk) disable iff (!hresetn)
        st.cfg[ANY_BIT] |-> frame_match)
        else $error("Any-frame bit not overriding");

    // Sequencing of requests and jams
    a_jam_no_retrig: assert property (@(posedge hclk) disable iff (!hresetn)
        $fell(jif.busy) |=> !jif.busy)
        else $error("Jam timer relaunched as it ended");
    a_jam_needs_cause: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(st.mode == AFC_JAM) |-> ($past(hit_hi && rx_frame_start && frame_match) || $past(st.sw_jam)))
        else $error("Jam without cause");
    a_idle_txoff: assert property (@(posedge hclk) disable iff (!hresetn)
        !st.tx_en |=> st.mode == AFC_IDLE)
        else $error("Flow control active while transmitter off");
    a_req_needs_tx: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(pause_req) |-> $past(st.tx_en))
        else $error("Pause raised while transmitter off");
    a_jam_mode_fd: assert property (@(posedge hclk) disable iff (!hresetn)
        st.fd |=> st.mode != AFC_JAM)
        else $error("Jam state in full duplex");
    a_zero_held: assert property (@(posedge hclk) disable iff (!hresetn)
        (pause_req && !pause_ack && st.tx_en) |=> $stable(pause_zero))
        else $error("Pause kind changed while pending");
    a_pause_fd_only: assert property (@(posedge hclk) disable iff (!hresetn)
        ($rose(pause_req) && !pause_zero) |-> ($past(st.fd) || $past(st.sw_pause)))
        else $error("Automatic pause outside full duplex");
    a_zero_needs_any: assert property (@(posedge hclk) disable iff (!hresetn)
        ($rose(pause_req) && pause_zero) |-> $past(st.cfg[ANY_BIT]))
        else $error("Zero pause with flow control off");
    a_hi_needs_level: assert property (@(posedge hclk) disable iff (!hresetn)
        $rose(st.above_hi) |-> $past(hit_hi))
        else $error("High state without high level");
endmodule

// ==== inc/afc_pkg.sv ====
// Package of constants and types for the automatic flow-control block
package afc_pkg;
    // ==========================================================
    // Register map
    localparam logic [7:0] CONFIG_OFFSET   = 8'hac;
    localparam logic [7:0] AFC_STAT_OFFSET = 8'hb4;
    localparam logic [7:0] AFC_SW_OFFSET   = 8'hb8;
    // ==========================================================
    // Field positions of the configuration register
    localparam int HI_LSB    = 16;
    localparam int LO_LSB    = 8;
    localparam int DUR_LSB   = 4;
    localparam int MULT_BIT  = 3;
    localparam int BRD_BIT   = 2;
    localparam int ADD_BIT   = 1;
    localparam int ANY_BIT   = 0;
    localparam int UNIT_SHIFT = 6;
    localparam logic [23:0] CFG_RESET = 24'h000000;
    localparam logic [23:0] CFG_MASK  = 24'hffffff;
    // ==========================================================
    // Timing
    localparam int CLK_MHZ = 50;
    localparam int TEN_EXTRA_NS = 2200;
    localparam int TEN_EXTRA_CYC = TEN_EXTRA_NS * CLK_MHZ / 1000;
    localparam int DUR_W = 15;
    // Jam times in ns for the fast link, per code
    localparam int DUR_NS [16] = '{5000, 10000, 15000, 25000, 50000, 100000, 150000, 200000,
                                   250000, 300000, 350000, 400000, 450000, 500000, 550000, 600000};
    // ==========================================================
    // Types
    typedef enum logic [1:0]
    {
        AFC_IDLE   = 2'b00,
        AFC_PAUSED = 2'b01,
        AFC_JAM    = 2'b10
    } afc_state_t;
endpackage

// ==== inc/afc_jam_if.sv ====
// Interface between the flow controller and its jam timer
`timescale 1ns/10ps
interface afc_jam_if;
    logic       start;
    logic [3:0] code;
    logic       speed_100;
    logic       busy;
    modport ctrl  (output start, output code, output speed_100, input busy);
    modport timer (input start, input code, input speed_100, output busy);
endinterface

// ==== src/afc_jam_timer.sv ====
// Back-pressure duration timer
`timescale 1ns/10ps
module afc_jam_timer
    import afc_pkg::*;
(
    input  wire logic hclk,
    input  wire logic hresetn,
    afc_jam_if.timer  jam
);
    typedef struct packed
    {
        logic [DUR_W-1:0] count;
        logic             busy;
    } afc_tmr_t;

    afc_tmr_t st;
    afc_tmr_t next_st;
    logic [DUR_W-1:0] load;

    always_comb
    begin
        load = DUR_W'(DUR_NS[jam.code] * CLK_MHZ / 1000);
        if (!jam.speed_100)
        begin
            load = load + DUR_W'(TEN_EXTRA_CYC);
        end
        next_st = st;
        if (jam.start && !st.busy)
        begin
            next_st.count = load - 1'b1;
            next_st.busy  = 1'b1;
        end
        else if (st.busy)
        begin
            if (st.count == '0)
            begin
                next_st.busy = 1'b0;
            end
            else
            begin
                next_st.count = st.count - 1'b1;
            end
        end
    end

    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            st <= '0;
        end
        else
        begin
            st <= next_st;
        end
    end

    assign jam.busy = st.busy;
endmodule

// ==== sim/afc_mac_model.sv ====
// Behavioural MAC on the far side: takes pause requests and counts the frames sent
`timescale 1ns/10ps
module afc_mac_model
(
    input  wire logic       hclk,
    input  wire logic       hresetn,
    input  wire logic       pause_req,
    input  wire logic       pause_zero,
    input  wire logic [7:0] ack_wait,
    output logic            pause_ack,
    output int              sent_pause,
    output int              sent_zero
);
    int   wait_cnt;
    logic taken;
    // ==========================================================
    // Request handling
    always_ff @(posedge hclk or negedge hresetn)
    begin
        if (!hresetn)
        begin
            pause_ack  <= 1'b0;
            taken      <= 1'b0;
            wait_cnt   <= 0;
            sent_pause <= 0;
            sent_zero  <= 0;
        end
        else
        begin
            pause_ack <= 1'b0;
            if (!pause_req)
            begin
                taken    <= 1'b0;
                wait_cnt <= 0;
            end
            else if (!taken)
            begin
                // Held until a transmit slot opens; ack_wait sets how slow
                if (wait_cnt >= int'(ack_wait))
                begin
                    pause_ack <= 1'b1;
                    taken     <= 1'b1;
                    if (pause_zero)
                        sent_zero <= sent_zero + 1;
                    else
                        sent_pause <= sent_pause + 1;
                end
                else
                    wait_cnt <= wait_cnt + 1;
            end
        end
    end
endmodule

// ==== sim/afc_flow_ctrl_tb_top.sv ====
// Self-checking bench for the automatic flow-control block
`timescale 1ns/10ps
module afc_flow_ctrl_tb_top
    import afc_pkg::*;
;
    localparam logic [31:0] cfg_addr  = {24'h000000, CONFIG_OFFSET};
    localparam logic [31:0] stat_addr = {24'h000000, AFC_STAT_OFFSET};
    localparam logic [31:0] sw_addr   = {24'h000000, AFC_SW_OFFSET};
    logic        hclk = 1'b0;
    logic        hresetn = 1'b0;
    logic        hsel = 1'b0;
    logic [31:0] haddr = 32'h00000000;
    logic [1:0]  htrans = 2'b00;
    logic        hwrite = 1'b0;
    logic [2:0]  hsize = 3'b010;
    logic [31:0] hwdata = 32'h00000000;
    logic [13:0] rx_fifo_used_bytes = 14'h0000;
    logic        full_duplex = 1'b0;
    logic        speed_100 = 1'b0;
    logic        tx_enabled = 1'b0;
    logic        rx_frame_start = 1'b0;
    logic        rx_multicast = 1'b0;
    logic        rx_broadcast = 1'b0;
    logic        rx_own_address = 1'b0;
    logic [7:0]  ack_wait = 8'h01;
    logic [31:0] rd;
    wire         hreadyout;
    wire         hresp;
    wire  [31:0] hrdata;
    wire         pause_req;
    wire         pause_zero;
    wire         pause_ack;
    wire         jam;
    int          sent_pause;
    int          sent_zero;
    int          errors = 0;
    int          checks_done = 0;
    int          cycles = 0;

    afc_flow_ctrl u_afc_flow_ctrl (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp),
        .hrdata(hrdata), .rx_fifo_used_bytes(rx_fifo_used_bytes), .full_duplex(full_duplex), .speed_100(speed_100),
        .tx_enabled(tx_enabled), .rx_frame_start(rx_frame_start), .rx_multicast(rx_multicast),
        .rx_broadcast(rx_broadcast), .rx_own_address(rx_own_address), .pause_req(pause_req),
        .pause_zero(pause_zero), .pause_ack(pause_ack), .jam(jam));
    afc_mac_model u_afc_mac_model (.hclk(hclk), .hresetn(hresetn), .pause_req(pause_req), .pause_zero(pause_zero),
        .ack_wait(ack_wait), .pause_ack(pause_ack), .sent_pause(sent_pause), .sent_zero(sent_zero));

    // ==========================================================
    // Clock and hang guard
    always #10 hclk = ~hclk;
    always @(posedge hclk)
    begin
        cycles++;
        if (cycles == 30000)
        begin
            errors++;
            conclude();
        end
    end
    // ==========================================================
    // Shared tasks
    task automatic conclude();
        if (errors == 0 && checks_done > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask
    task automatic check_word(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp)
        begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Jam lengths get two cycles of slack for the pin filter and start delay
    task automatic check_len(input int got, input int exp);
        checks_done++;
        if (got < exp - 2 || got > exp + 2 || (exp == 0 && got != 0))
        begin
            errors++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    // Only the run's own timeout ends a wait for ready
    task automatic wait_ready();
        @(posedge hclk);
        while (hreadyout !== 1'b1)
        begin
            @(posedge hclk);
        end
    endtask
    task automatic bus(input logic [31:0] a, input logic wr, input logic [31:0] wd);
        hsel <= 1'b1;
        haddr <= a;
        hwrite <= wr;
        hsize <= 3'b010;
        htrans <= 2'b10;
        wait_ready();
        hsel <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        wait_ready();
        rd = hrdata;
    endtask
    // Pin levels pass a filter, so give them time to land
    task automatic set_link(input logic fd, input logic fast, input logic tx);
        full_duplex <= fd;
        speed_100 <= fast;
        tx_enabled <= tx;
        repeat (8) @(posedge hclk);
    endtask
    task automatic set_occ(input logic [13:0] v);
        rx_fifo_used_bytes <= v;
        repeat (20) @(posedge hclk);
    endtask
    function automatic int dur_cyc(input int code, input logic fast);
        return (DUR_NS[code] + (fast ? 0 : TEN_EXTRA_NS)) / 20;
    endfunction
    task automatic frame(input logic [2:0] f, input int exp);
        int n;
        int len;
        rx_frame_start <= 1'b1;
        {rx_multicast, rx_broadcast, rx_own_address} <= f;
        @(posedge hclk);
        rx_frame_start <= 1'b0;
        {rx_multicast, rx_broadcast, rx_own_address} <= 3'b000;
        n = 0;
        len = 0;
        while (jam !== 1'b1 && n < 10)
        begin
            @(posedge hclk);
            n++;
        end
        while (jam === 1'b1 && len < 40000)
        begin
            @(posedge hclk);
            len++;
        end
        check_len(len, exp);
        repeat (20) @(posedge hclk);
    endtask
    // ==========================================================
    // Scenarios
    task automatic t_regs();
        bus(cfg_addr, 1'b0, 32'h0);
        check_word(rd, 32'h00000000);
        bus(cfg_addr, 1'b1, 32'hffff7fff);
        bus(cfg_addr, 1'b0, 32'h0);
        check_word(rd, 32'h00ff7fff);
        bus(32'h00000040, 1'b1, 32'h12345678);
        bus(32'h00000040, 1'b0, 32'h0);
        check_word(rd, 32'h00000000);
        bus(cfg_addr, 1'b1, 32'h00020101);
    endtask
    task automatic t_pause();
        set_link(1'b1, 1'b1, 1'b1);
        set_occ(14'd0);
        check_word(sent_zero, 0);
        set_occ(14'd127);
        check_word(sent_pause, 0);
        set_occ(14'd128);
        check_word(sent_pause, 1);
        repeat (200) @(posedge hclk);
        check_word(sent_pause, 1);
        set_occ(14'd64);
        check_word(sent_zero, 0);
        set_occ(14'd63);
        check_word(sent_zero, 1);
        ack_wait <= 8'd12;
        set_occ(14'd300);
        check_word(sent_pause, 2);
        set_occ(14'd0);
        check_word(sent_zero, 2);
        bus(cfg_addr, 1'b1, 32'h0002010e);
        set_occ(14'd300);
        check_word(sent_pause, 2);
        set_occ(14'd0);
    endtask
    task automatic t_tx_off();
        bus(cfg_addr, 1'b1, 32'h00020101);
        ack_wait <= 8'd200;
        set_occ(14'd200);
        check_word({31'h0, pause_req}, 32'h1);
        frame(3'b111, 0);
        set_link(1'b1, 1'b1, 1'b0);
        repeat (60) @(posedge hclk);
        check_word({31'h0, pause_req}, 32'h0);
        check_word(sent_pause, 2);
        ack_wait <= 8'd1;
        frame(3'b111, 0);
    endtask
    // Status word and software triggers, transmitter first off, then on
    task automatic t_sw();
        bus(stat_addr, 1'b0, 32'h0);
        check_word(rd, 32'h00000060);
        check_word({31'h0, hresp}, 32'h0);
        bus(sw_addr, 1'b1, 32'h00000003);
        set_occ(14'd0);
        check_word(sent_pause, 2);
        set_link(1'b1, 1'b1, 1'b1);
        bus(sw_addr, 1'b1, 32'h00000003);
        set_occ(14'd0);
        check_word(sent_pause, 3);
        check_word({31'h0, jam}, 32'h0);
    endtask
    task automatic t_jam();
        int k;
        set_link(1'b0, 1'b1, 1'b1);
        set_occ(14'd200);
        for (k = 1; k < 4; k++)
        begin
            bus(cfg_addr, 1'b1, 32'h00020100 | (32'h1 << k));
            frame(~(3'b001 << (k - 1)), 0);
            frame(3'b001 << (k - 1), dur_cyc(0, 1'b1));
        end
        bus(cfg_addr, 1'b1, 32'h00020101);
        frame(3'b000, dur_cyc(0, 1'b1));
        bus(cfg_addr, 1'b1, 32'h00020131);
        set_link(1'b0, 1'b0, 1'b1);
        frame(3'b000, dur_cyc(3, 1'b0));
        set_occ(14'd127);
        frame(3'b111, 0);
        bus(sw_addr, 1'b1, 32'h00000002);
        frame(3'b000, dur_cyc(3, 1'b0));
        set_occ(14'd200);
        set_link(1'b0, 1'b0, 1'b0);
        frame(3'b111, 0);
    endtask
    // ==========================================================
    // Main sequence
    initial
    begin
        repeat (16) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        t_regs();
        t_pause();
        t_tx_off();
        t_sw();
        t_jam();
        conclude();
    end
endmodule
